// file: refetch_pkg.sv
// Purpose: constants for the write-wait and re-fetch inhibit control block
// Assumes: 32-bit Avalon-MM register slave, word addressed by byte address
// Notes: both control registers reset to zero
`default_nettype none
package refetch_pkg;
    localparam logic [3:0] PHYS_SPACE_CTRL_OFFSET = 4'h0;
    localparam logic [3:0] REFETCH_INHIBIT_OFFSET = 4'h4;
    localparam logic [31:0] PHYS_SPACE_CTRL_RESET = 32'h00000000;
    localparam logic [31:0] REFETCH_INHIBIT_RESET = 32'h00000000;
    localparam int AREA_COUNT = 8;
    localparam int CTRL_AREA_BIT = 7;
    localparam int INHIBIT_WIDTH = 5;
    localparam int INH_CORE_REGS_BIT = 4;
    localparam int INH_PERIPH_REGS_BIT = 3;
    localparam int INH_TLB_LOAD_BIT = 2;
    localparam int INH_TLB_ARRAY_BIT = 1;
    localparam int INH_ICACHE_ARRAY_BIT = 0;
    localparam logic [31:0] PERIPH_REG_BASE = 32'hFF200000;
    localparam logic [31:0] PERIPH_REG_LAST = 32'hFF2FFFFF;
    localparam logic [1:0] AREA_SHIFT_HI = 2'h2;
    typedef enum logic [2:0] {
        WW_IDLE = 3'b001,
        WW_PENDING = 3'b010,
        WW_STALL = 3'b100
    } write_wait_state_t;
endpackage
`default_nettype wire

// file: write_wait_tracker.sv
// Purpose: tracks an outstanding write for one area and stalls the next access
// Assumes: write_issue_in pulses when a posted write leaves, write_done_in when it ends
// Notes: one outstanding tracked write at a time
`timescale 1ns/100ps
`default_nettype none
module write_wait_tracker (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic write_issue_in,
    input wire logic wait_enable_in,
    input wire logic write_done_in,
    input wire logic next_access_in,
    output logic stall_out
);
    refetch_pkg::write_wait_state_t state_q;
    refetch_pkg::write_wait_state_t state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            refetch_pkg::WW_IDLE: begin
                if (write_issue_in && wait_enable_in && !write_done_in) begin
                    state_d = refetch_pkg::WW_PENDING;
                end
            end
            refetch_pkg::WW_PENDING: begin
                if (write_done_in) begin
                    state_d = refetch_pkg::WW_IDLE;
                end else if (next_access_in) begin
                    state_d = refetch_pkg::WW_STALL;
                end
            end
            refetch_pkg::WW_STALL: begin
                if (write_done_in) begin
                    state_d = refetch_pkg::WW_IDLE;
                end
            end
            default: state_d = refetch_pkg::WW_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= refetch_pkg::WW_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // combinational so a stall holds the access in the same cycle it is asked
    assign stall_out = (state_q != refetch_pkg::WW_IDLE) && next_access_in && !write_done_in;
endmodule
`default_nettype wire

// file: refetch_control.sv
// Purpose: physical space write-wait control and instruction re-fetch inhibit control
// Assumes: core reports resource change events as one-cycle pulses
// Notes: registers over Avalon-MM, one wait state per access
//        bus_stall_out is combinational; every other output is a flip-flop
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module refetch_control #(
    parameter int AREAS = refetch_pkg::AREA_COUNT
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // ****************
    // register bus
    // ****************
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic [1:0] avs_response_out,
    // ****************
    // bus interface side
    // ****************
    input wire logic [2:0] wr_area_in,
    input wire logic wr_issue_in,
    input wire logic wr_uncached_in,
    input wire logic wr_through_in,
    input wire logic wr_done_in,
    input wire logic next_access_in,
    output logic [2:0] next_area_out,
    output logic bus_stall_out,
    // ****************
    // pipeline side
    // ****************
    input wire logic core_reg_change_in,
    input wire logic [31:0] reg_change_addr_in,
    input wire logic reg_change_in,
    input wire logic tlb_load_in,
    input wire logic tlb_array_write_in,
    input wire logic translation_on_in,
    input wire logic icache_array_write_in,
    input wire logic icache_on_in,
    output logic refetch_out,
    output logic [AREAS-1:0] area_write_wait_out,
    output logic [refetch_pkg::INHIBIT_WIDTH-1:0] refetch_inhibit_control_out
);
    logic [AREAS-1:0] area_write_wait_q;
    logic [refetch_pkg::INHIBIT_WIDTH-1:0] inhibit_q;
    logic waitreq_q;
    logic [31:0] rdata_q;
    logic [1:0] resp_q;
    logic refetch_q;
    logic [2:0] area_q;
    logic [AREAS-1:0] stall_vec;
    logic [AREAS-1:0] issue_vec;
    logic tracked_write;
    logic periph_change;
    logic pasc_wr_en;
    logic inh_wr_en;
    logic [31:0] pasc_merged;
    logic [31:0] inh_merged;
    logic [refetch_pkg::INHIBIT_WIDTH-1:0] refetch_cause;

    function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // register select, shared by the write enables and the read mux
    function automatic logic addr_hit(input logic [3:0] addr, input logic [3:0] offset);
        return addr == offset;
    endfunction

    // both end addresses of the window count as inside it
    function automatic logic in_periph_window(input logic [31:0] addr);
        return (addr >= refetch_pkg::PERIPH_REG_BASE) && (addr <= refetch_pkg::PERIPH_REG_LAST);
    endfunction

    // ****************
    // register access
    // ****************
    // waitrequest idles high and drops for one cycle, the cycle after a request is first seen
    wire logic access = (avs_read_in || avs_write_in) && waitreq_q;
    wire logic hit_pasc = addr_hit(avs_address_in, refetch_pkg::PHYS_SPACE_CTRL_OFFSET);
    wire logic hit_inh = addr_hit(avs_address_in, refetch_pkg::REFETCH_INHIBIT_OFFSET);

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            waitreq_q <= 1'b1;
        end else begin
            waitreq_q <= !access;
        end
    end

    assign avs_waitrequest_out = waitreq_q;

    // a write lands only at the edge where the master sees waitrequest low,
    // so a request that is still waiting never changes a register early
    assign pasc_wr_en = avs_write_in && !waitreq_q && hit_pasc;
    assign inh_wr_en = avs_write_in && !waitreq_q && hit_inh;

    // byte lanes merge first; bits above each field are dropped, as they read zero
    always_comb begin
        pasc_merged = be_merge({{(32-AREAS){1'b0}}, area_write_wait_q}, avs_writedata_in, avs_byteenable_in);
        inh_merged = be_merge({{(32-refetch_pkg::INHIBIT_WIDTH){1'b0}}, inhibit_q}, avs_writedata_in,
                              avs_byteenable_in);
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            area_write_wait_q <= refetch_pkg::PHYS_SPACE_CTRL_RESET[AREAS-1:0];
        end else if (pasc_wr_en) begin
            area_write_wait_q <= pasc_merged[AREAS-1:0];
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            inhibit_q <= refetch_pkg::REFETCH_INHIBIT_RESET[refetch_pkg::INHIBIT_WIDTH-1:0];
        end else if (inh_wr_en) begin
            inhibit_q <= inh_merged[refetch_pkg::INHIBIT_WIDTH-1:0];
        end
    end

    // unmapped addresses read zero with a slave error response
    // read data and response are taken at the request edge and stand until the next access
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_q <= 32'h00000000;
            resp_q <= 2'h0;
        end else if (access) begin
            if (hit_pasc) begin
                rdata_q <= {{(32-AREAS){1'b0}}, area_write_wait_q};
                resp_q <= 2'h0;
            end else if (hit_inh) begin
                rdata_q <= {27'h0000000, inhibit_q};
                resp_q <= 2'h0;
            end else begin
                rdata_q <= 32'h00000000;
                resp_q <= 2'h2;
            end
        end
    end

    assign avs_readdata_out = rdata_q;
    assign avs_response_out = resp_q;

    // ****************
    // write-wait sequencing
    // ****************
    // copy-back writes are posted freely and never tracked
    assign tracked_write = wr_issue_in && (wr_uncached_in || wr_through_in);

    // area index equals bit index: area 7 is the control register area
    genvar g;
    generate
        for (g = 0; g < AREAS; g++) begin : g_area
            assign issue_vec[g] = tracked_write && (wr_area_in == 3'(g));
            write_wait_tracker u_trk (
                .clk_in(clk_in),
                .sys_rst_in(sys_rst_in),
                .write_issue_in(issue_vec[g]),
                .wait_enable_in(area_write_wait_q[g]),
                .write_done_in(wr_done_in),
                .next_access_in(next_access_in),
                .stall_out(stall_vec[g])
            );
        end
    endgenerate

    // remembers where the last tracked write went
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            area_q <= 3'h0;
        end else if (tracked_write) begin
            area_q <= wr_area_in;
        end
    end

    assign next_area_out = area_q;
    // limitation: one outstanding tracked write is assumed, a done pulse retires every tracker;
    // the stall stays combinational so the access is held in the cycle it is asked for
    assign bus_stall_out = |stall_vec;
    assign area_write_wait_out = area_write_wait_q;
    assign refetch_inhibit_control_out = inhibit_q;

    // ****************
    // re-fetch request
    // ****************
    assign periph_change = reg_change_in && in_periph_window(reg_change_addr_in);

    // one cause bit for each inhibit bit, in the register's own bit order
    always_comb begin
        refetch_cause = '0;
        refetch_cause[refetch_pkg::INH_CORE_REGS_BIT] = core_reg_change_in;
        refetch_cause[refetch_pkg::INH_PERIPH_REGS_BIT] = periph_change;
        refetch_cause[refetch_pkg::INH_TLB_LOAD_BIT] = tlb_load_in;
        refetch_cause[refetch_pkg::INH_TLB_ARRAY_BIT] = tlb_array_write_in && translation_on_in;
        refetch_cause[refetch_pkg::INH_ICACHE_ARRAY_BIT] = icache_array_write_in && icache_on_in;
    end

    // pulse tells the pipeline to flush younger fetches and fetch again;
    // registered, so the pipeline sees it one cycle after the change
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            refetch_q <= 1'b0;
        end else begin
            refetch_q <= |(refetch_cause & ~inhibit_q);
        end
    end

    assign refetch_out = refetch_q;
endmodule
`default_nettype wire

// file: refetch_control_chk.sv
// Purpose: port-level checks for refetch_control
// Assumes: one clock, reset high
// Notes: bound into every refetch_control instance
`timescale 1ns/100ps
`default_nettype none
module refetch_control_chk #(
    parameter int AREAS = 8
) (
    input wire logic clk_in, sys_rst_in, avs_read_in, avs_write_in, avs_waitrequest_out,
    input wire logic [2:0] wr_area_in, next_area_out,
    input wire logic wr_issue_in, wr_uncached_in, wr_through_in, wr_done_in, next_access_in, bus_stall_out,
    input wire logic core_reg_change_in, reg_change_in, tlb_load_in, tlb_array_write_in, icache_array_write_in,
    input wire logic translation_on_in, icache_on_in, refetch_out,
    input wire logic [31:0] reg_change_addr_in,
    input wire logic [AREAS-1:0] area_write_wait_out,
    input wire logic [4:0] refetch_inhibit_control_out
);
    wire logic in_rng = reg_change_addr_in >= refetch_pkg::PERIPH_REG_BASE
        && reg_change_addr_in <= refetch_pkg::PERIPH_REG_LAST;
    wire logic [4:0] cause = {core_reg_change_in, reg_change_in && in_rng, tlb_load_in,
        tlb_array_write_in && translation_on_in, icache_array_write_in && icache_on_in};
    wire logic want = |(cause & ~refetch_inhibit_control_out);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    chk_ack_one_cycle: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("ack held too long");
    chk_ack_follows_req: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("ack missing");
    chk_refetch_cause: assert property (want |=> refetch_out)
        else $error("refetch missing");
    chk_refetch_only: assert property (refetch_out |-> $past(want))
        else $error("refetch without cause");
    chk_stall_tracked: assert property ((wr_issue_in && (wr_uncached_in || wr_through_in)
        && area_write_wait_out[wr_area_in] && !wr_done_in) ##1 (next_access_in && !wr_done_in)
        |-> bus_stall_out) else $error("stall missing");
    chk_stall_needs_access: assert property (bus_stall_out |-> next_access_in)
        else $error("stall without access");
    chk_stall_area_bit: assert property (bus_stall_out |-> area_write_wait_out[next_area_out])
        else $error("stall with bit clear");
    chk_stall_release: assert property (wr_done_in && !wr_issue_in |=> !bus_stall_out)
        else $error("stall after done");
endmodule
bind refetch_control refetch_control_chk #(.AREAS(AREAS)) u_chk (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_waitrequest_out(avs_waitrequest_out),
    .wr_area_in(wr_area_in),
    .next_area_out(next_area_out),
    .wr_issue_in(wr_issue_in),
    .wr_uncached_in(wr_uncached_in),
    .wr_through_in(wr_through_in),
    .wr_done_in(wr_done_in),
    .next_access_in(next_access_in),
    .bus_stall_out(bus_stall_out),
    .core_reg_change_in(core_reg_change_in),
    .reg_change_in(reg_change_in),
    .tlb_load_in(tlb_load_in),
    .tlb_array_write_in(tlb_array_write_in),
    .icache_array_write_in(icache_array_write_in),
    .translation_on_in(translation_on_in),
    .icache_on_in(icache_on_in),
    .refetch_out(refetch_out),
    .reg_change_addr_in(reg_change_addr_in),
    .area_write_wait_out(area_write_wait_out),
    .refetch_inhibit_control_out(refetch_inhibit_control_out)
);
`default_nettype wire

// file: cpu_bus_model.sv
// Purpose: behavioural bus interface of the core
// Assumes: tasks are called at a rising edge
// Notes: a released area bus shows the inverse of its last value
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_model (
    input wire logic clk_in,
    output logic [2:0] wr_area_out,
    output logic wr_issue_out,
    output logic wr_uncached_out,
    output logic wr_through_out,
    output logic wr_done_out,
    output logic next_access_out
);
    initial {wr_area_out, wr_issue_out, wr_uncached_out, wr_through_out, wr_done_out, next_access_out} = '0;
    task automatic put(input logic [2:0] a, input logic u, input logic t);
        wr_area_out <= a;
        wr_uncached_out <= u;
        wr_through_out <= t;
        wr_issue_out <= 1'b1;
        @(posedge clk_in);
        wr_issue_out <= 1'b0;
        wr_area_out <= ~a;
    endtask
    task automatic fin();
        wr_done_out <= 1'b1;
        @(posedge clk_in);
        wr_done_out <= 1'b0;
    endtask
    task automatic ask(input logic v);
        next_access_out <= v;
    endtask
endmodule
`default_nettype wire

// file: write_buffer_refetch_control_tb_top.sv
// Purpose: self-checking bench for refetch_control
// Assumes: one wait state per register access
// Notes: byte enables stay all ones
`timescale 1ns/100ps
`default_nettype none
module write_buffer_refetch_control_tb_top;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [3:0] avs_address_in = '0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = '0;
    wire logic [3:0] avs_byteenable_in = 4'hF;
    wire logic [31:0] avs_readdata_out;
    wire logic [1:0] avs_response_out;
    wire logic [2:0] wr_area_in, next_area_out;
    wire logic avs_waitrequest_out, wr_issue_in, wr_uncached_in, wr_through_in, wr_done_in;
    wire logic next_access_in, bus_stall_out, refetch_out;
    logic [31:0] reg_change_addr_in = 32'hFF200000;
    logic translation_on_in = 1'b1;
    logic icache_on_in = 1'b1;
    logic [4:0] ev = '0;
    wire logic core_reg_change_in = ev[4];
    wire logic reg_change_in = ev[3];
    wire logic tlb_load_in = ev[2];
    wire logic tlb_array_write_in = ev[1];
    wire logic icache_array_write_in = ev[0];
    wire logic [7:0] area_write_wait_out;
    wire logic [4:0] refetch_inhibit_control_out;
    logic [31:0] q;
    logic [1:0] rs;
    int n_fail = 0;
    int samples_checked = 0;
    refetch_control #(.AREAS(8)) dut (.*);
    cpu_bus_model m (.clk_in(clk_in), .wr_area_out(wr_area_in), .wr_issue_out(wr_issue_in),
        .wr_uncached_out(wr_uncached_in), .wr_through_out(wr_through_in), .wr_done_out(wr_done_in),
        .next_access_out(next_access_in));
    initial forever #25 clk_in = ~clk_in;
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // request held until the edge that samples waitrequest low
    task automatic acc(input logic r, input logic [3:0] a, input logic [31:0] d);
        int i;
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_read_in <= r;
        avs_write_in <= !r;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_in);
            if (avs_waitrequest_out === 1'b0) break;
        end
        q = avs_readdata_out;
        rs = avs_response_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        @(posedge clk_in);
        if (i == 20) begin
            n_fail++;
            summarize();
        end
    endtask
    task automatic rf(input int b, input logic [4:0] inh, input logic e);
        acc(1'b0, 4'h4, {27'h0, inh});
        ev[b] <= 1'b1;
        @(posedge clk_in);
        ev <= '0;
        @(posedge clk_in);
        chk("refetch", {31'h0, refetch_out}, {31'h0, e});
    endtask
    task automatic ww(input logic [2:0] a, input logic u, input logic t, input logic e);
        m.put(a, u, t);
        m.ask(1'b1);
        @(posedge clk_in);
        chk("stall", {31'h0, bus_stall_out}, {31'h0, e});
        m.fin();
        @(posedge clk_in);
        chk("stall_done", {31'h0, bus_stall_out}, 32'h0);
        m.ask(1'b0);
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        chk("inh_out_rst", {27'h0, refetch_inhibit_control_out}, refetch_pkg::REFETCH_INHIBIT_RESET);
        acc(1'b1, 4'h0, 32'h0);
        chk("space_rst", q, refetch_pkg::PHYS_SPACE_CTRL_RESET);
        chk("space_rst_resp", {30'h0, rs}, 32'h0);
        acc(1'b1, 4'h4, 32'h0);
        chk("inhibit_rst", q, refetch_pkg::REFETCH_INHIBIT_RESET);
        acc(1'b0, 4'h0, 32'hFFFFFFFF);
        acc(1'b1, 4'h0, 32'h0);
        chk("space", q, 32'h000000FF);
        chk("ww_out", {24'h0, area_write_wait_out}, 32'h000000FF);
        acc(1'b0, 4'h4, 32'hFFFFFFFF);
        chk("inh_out", {27'h0, refetch_inhibit_control_out}, 32'h0000001F);
        acc(1'b1, 4'h4, 32'h0);
        chk("inhibit", q, 32'h0000001F);
        acc(1'b0, 4'h8, 32'h0);
        acc(1'b1, 4'h8, 32'h0);
        chk("unmapped", q, 32'h0);
        chk("resp", {30'h0, rs}, 32'h2);
        $display("test registers done");
        for (int b = 0; b < 5; b++) begin
            rf(b, 5'h00, 1'b1);
            rf(b, 5'h01 << b, 1'b0);
            rf(b, ~(5'h01 << b), 1'b1);
        end
        translation_on_in <= 1'b0;
        icache_on_in <= 1'b0;
        reg_change_addr_in <= 32'hFF300000;
        rf(1, 5'h00, 1'b0);
        rf(0, 5'h00, 1'b0);
        rf(3, 5'h00, 1'b0);
        reg_change_addr_in <= 32'hFF1FFFFF;
        rf(3, 5'h00, 1'b0);
        reg_change_addr_in <= 32'hFF2FFFFF;
        rf(3, 5'h00, 1'b1);
        $display("test refetch done");
        acc(1'b0, 4'h0, 32'h00000080);
        ww(3'h7, 1'b1, 1'b0, 1'b1);
        chk("next_area", {29'h0, next_area_out}, 32'h7);
        ww(3'h7, 1'b0, 1'b1, 1'b1);
        ww(3'h7, 1'b0, 1'b0, 1'b0);
        ww(3'h5, 1'b0, 1'b0, 1'b0);
        chk("next_area_cb", {29'h0, next_area_out}, 32'h7);
        ww(3'h6, 1'b1, 1'b0, 1'b0);
        chk("next_area_6", {29'h0, next_area_out}, 32'h6);
        $display("test write wait done");
        summarize();
    end
endmodule
`default_nettype wire
